/* File: rtl/crbfr_top.sv */
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "crbfr_map.svh"

module crbfr_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // axi4-lite write address
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [11:0] s_axi_awaddr_in,
  // axi4-lite write data
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // axi4-lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // axi4-lite read address
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [11:0] s_axi_araddr_in,
  // axi4-lite read data
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // received frames and error events from the bit-level receiver
  input wire crbfr_pkg::crbfr_frame_t rx_frame_in,
  input wire logic rx_frame_valid_in,
  input wire logic rx_error_in,
  input wire logic rx_error_dominant_in,
  // status
  output logic error_passive_out,
  output logic [1:0] buffer_full_out
);

  // merge a write into a word under the byte strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strb

  // length code to byte count; nine and above are not counts
  function automatic crbfr_pkg::crbfr_len_t decode_len(input logic [3:0] code);
    crbfr_pkg::crbfr_len_t r;
    r.invalid = (code > `CRBFR_LEN_MAX);
    r.count = r.invalid ? 4'h0 : code;
    return r;
  endfunction : decode_len

  // counter step that sticks at the top instead of wrapping
  function automatic logic [7:0] sat_add(input logic [7:0] val, input logic [7:0] step);
    logic [8:0] sum;
    sum = {1'b0, val} + {1'b0, step};
    return sum[8] ? 8'hff : sum[7:0];
  endfunction : sat_add

  // byte address to register; unaligned or unused words give none
  function automatic crbfr_pkg::crbfr_dec_t decode_addr(input logic [11:0] a);
    crbfr_pkg::crbfr_dec_t d;
    d.kind = crbfr_pkg::REG_NONE;
    d.idx = 1'b0;
    d.byte_sel = a[4:2];
    if (a[1:0] != 2'h0)
    begin
      d.kind = crbfr_pkg::REG_NONE;
    end
    else if (a < `CRBFR_FLT_BASE)
    begin
      d.idx = a[6];
      if (!a[5])
        d.kind = crbfr_pkg::REG_DATA;
      else if (a[5:0] == `CRBFR_BUF_LEN)
        d.kind = crbfr_pkg::REG_LEN;
      else if (a[5:0] == `CRBFR_BUF_IDENT)
        d.kind = crbfr_pkg::REG_IDENT;
      else if (a[5:0] == `CRBFR_BUF_STAT)
        d.kind = crbfr_pkg::REG_STAT;
    end
    else if (a < `CRBFR_FLT_BASE + `CRBFR_BANK_SPAN)
    begin
      d.idx = a[4];
      if (a[3:0] == `CRBFR_ID_HIGH)
        d.kind = crbfr_pkg::REG_FHIGH;
      else if (a[3:0] == `CRBFR_ID_LOW)
        d.kind = crbfr_pkg::REG_FLOW;
      else if (a[3:0] == `CRBFR_ID_EXT)
        d.kind = crbfr_pkg::REG_FEXT;
    end
    else if (a >= `CRBFR_MSK_BASE && a < `CRBFR_MSK_BASE + `CRBFR_BANK_SPAN)
    begin
      d.idx = a[4];
      if (a[3:0] == `CRBFR_ID_HIGH)
        d.kind = crbfr_pkg::REG_MHIGH;
      else if (a[3:0] == `CRBFR_ID_LOW)
        d.kind = crbfr_pkg::REG_MLOW;
      else if (a[3:0] == `CRBFR_ID_EXT)
        d.kind = crbfr_pkg::REG_MEXT;
    end
    else if (a == `CRBFR_REC)
      d.kind = crbfr_pkg::REG_REC;
    else if (a == `CRBFR_ERR_STAT)
      d.kind = crbfr_pkg::REG_ERR;
    return d;
  endfunction : decode_addr

  // bus slave state
  logic aw_held, next_aw_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic b_valid, next_b_valid;
  logic [1:0] b_resp, next_b_resp;
  logic r_valid, next_r_valid;
  logic [31:0] r_data, next_r_data;
  logic [1:0] r_resp, next_r_resp;
  logic wr_fire;
  crbfr_pkg::crbfr_dec_t wr_dec;
  crbfr_pkg::crbfr_dec_t rd_dec;
  logic [31:0] rd_word;
  crbfr_pkg::crbfr_len_t rd_len;

  // buffer storage; data, length and identifier carry no reset
  logic [1:0][7:0][7:0] buf_data, next_buf_data;
  logic [1:0][7:0] buf_len, next_buf_len;
  logic [1:0][29:0] buf_ident, next_buf_ident;
  logic [1:0] buf_full, next_buf_full;
  logic [1:0] buf_over, next_buf_over;

  // filters, masks and the error counter
  crbfr_pkg::crbfr_ident_t [1:0] filt, next_filt;
  crbfr_pkg::crbfr_ident_t [1:0] mask, next_mask;
  logic [7:0] rec, next_rec;
  logic passive, next_passive;
  logic [1:0] hit;

  // one comparator per buffer: filter n and mask n feed buffer n
  for (genvar n = 0; n < 2; n++)
  begin : g_accept
    crbfr_accept u_accept (
      .filter_in(filt[n]),
      .mask_in(mask[n]),
      .ident_in(rx_frame_in.ident),
      .extended_in(rx_frame_in.extended),
      .hit_out(hit[n])
    );
  end

  assign wr_fire = aw_held && w_held && !b_valid;
  assign wr_dec = decode_addr(aw_addr);
  assign rd_dec = decode_addr(s_axi_araddr_in);

  // handshakes; address and data are taken in either order
  assign s_axi_awready_out = !aw_held && !b_valid;
  assign s_axi_wready_out = !w_held && !b_valid;
  assign s_axi_arready_out = !r_valid;
  assign s_axi_bvalid_out = b_valid;
  assign s_axi_bresp_out = b_resp;
  assign s_axi_rvalid_out = r_valid;
  assign s_axi_rdata_out = r_data;
  assign s_axi_rresp_out = r_resp;
  assign error_passive_out = passive;
  assign buffer_full_out = buf_full;

  // read mux; unimplemented bits come back as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_len = decode_len(buf_len[rd_dec.idx][3:0]);
    unique case (rd_dec.kind)
      crbfr_pkg::REG_DATA: rd_word[7:0] = buf_data[rd_dec.idx][rd_dec.byte_sel];
      crbfr_pkg::REG_LEN: rd_word[7:0] = buf_len[rd_dec.idx];
      crbfr_pkg::REG_IDENT: rd_word[29:0] = buf_ident[rd_dec.idx];
      crbfr_pkg::REG_STAT:
      begin
        rd_word[`CRBFR_STAT_FULL_BIT] = buf_full[rd_dec.idx];
        rd_word[`CRBFR_STAT_INVALID_BIT] = rd_len.invalid;
        rd_word[`CRBFR_STAT_OVER_BIT] = buf_over[rd_dec.idx];
        rd_word[7:4] = rd_len.count;
      end
      crbfr_pkg::REG_FHIGH: rd_word[7:0] = filt[rd_dec.idx].high;
      crbfr_pkg::REG_FLOW: rd_word[7:0] = filt[rd_dec.idx].low;
      crbfr_pkg::REG_FEXT: rd_word[15:0] = filt[rd_dec.idx].ext;
      crbfr_pkg::REG_MHIGH: rd_word[7:0] = mask[rd_dec.idx].high;
      crbfr_pkg::REG_MLOW: rd_word[7:0] = mask[rd_dec.idx].low;
      crbfr_pkg::REG_MEXT: rd_word[15:0] = mask[rd_dec.idx].ext;
      crbfr_pkg::REG_REC: rd_word[7:0] = rec;
      crbfr_pkg::REG_ERR: rd_word[0] = passive;
      crbfr_pkg::REG_NONE: rd_word = 32'h0000_0000;
    endcase
  end

  // bus slave next state: one write and one read in flight at most
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_b_valid = b_valid;
    next_b_resp = b_resp;
    next_r_valid = r_valid;
    next_r_data = r_data;
    next_r_resp = r_resp;
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_in;
      next_w_strb = s_axi_wstrb_in;
    end
    if (b_valid && s_axi_bready_in)
    begin
      next_b_valid = 1'b0;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_b_valid = 1'b1;
      next_b_resp = (wr_dec.kind == crbfr_pkg::REG_NONE) ? `CRBFR_RESP_SLVERR
                                                         : `CRBFR_RESP_OKAY;
    end
    if (r_valid && s_axi_rready_in)
    begin
      next_r_valid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      next_r_valid = 1'b1;
      next_r_data = rd_word;
      next_r_resp = (rd_dec.kind == crbfr_pkg::REG_NONE) ? `CRBFR_RESP_SLVERR
                                                         : `CRBFR_RESP_OKAY;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      b_valid <= 1'b0;
      b_resp <= `CRBFR_RESP_OKAY;
      r_valid <= 1'b0;
      r_data <= 32'h0000_0000;
      r_resp <= `CRBFR_RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      b_valid <= next_b_valid;
      b_resp <= next_b_resp;
      r_valid <= next_r_valid;
      r_data <= next_r_data;
      r_resp <= next_r_resp;
    end
  end

  // buffers: software writes first, a stored frame overrides them
  always_comb
  begin
    logic found;
    logic [31:0] merged;
    crbfr_pkg::crbfr_len_t len_info;
    found = 1'b0;
    merged = 32'h0000_0000;
    len_info = decode_len(rx_frame_in.length_code);
    next_buf_data = buf_data;
    next_buf_len = buf_len;
    next_buf_ident = buf_ident;
    next_buf_full = buf_full;
    next_buf_over = buf_over;
    if (wr_fire)
    begin
      unique case (wr_dec.kind)
        crbfr_pkg::REG_DATA:
        begin
          merged = apply_strb({24'h000000, buf_data[wr_dec.idx][wr_dec.byte_sel]},
                              w_data, w_strb);
          next_buf_data[wr_dec.idx][wr_dec.byte_sel] = merged[7:0];
        end
        crbfr_pkg::REG_LEN:
        begin
          merged = apply_strb({24'h000000, buf_len[wr_dec.idx]}, w_data, w_strb);
          next_buf_len[wr_dec.idx] = merged[7:0] & `CRBFR_LEN_IMPL;
        end
        crbfr_pkg::REG_IDENT:
        begin
          merged = apply_strb({2'h0, buf_ident[wr_dec.idx]}, w_data, w_strb);
          next_buf_ident[wr_dec.idx] = merged[29:0];
        end
        crbfr_pkg::REG_STAT:
        begin
          // write one to release the buffer or clear the overrun flag
          if (w_strb[0] && w_data[`CRBFR_STAT_FULL_BIT])
            next_buf_full[wr_dec.idx] = 1'b0;
          if (w_strb[0] && w_data[`CRBFR_STAT_OVER_BIT])
            next_buf_over[wr_dec.idx] = 1'b0;
        end
        default:
        begin
          merged = 32'h0000_0000;
        end
      endcase
    end
    // lowest matching buffer takes the frame; a full one flags overrun
    for (int n = 0; n < 2; n++)
    begin
      if (rx_frame_valid_in && hit[n] && !found)
      begin
        found = 1'b1;
        if (buf_full[n])
        begin
          next_buf_over[n] = 1'b1;
        end
        else
        begin
          for (int m = 0; m < 8; m++)
          begin
            if (m < int'(len_info.count))
              next_buf_data[n][m] = rx_frame_in.data[m];
          end
          next_buf_len[n] = {1'b0, rx_frame_in.rtr, 2'h0, rx_frame_in.length_code};
          // standard field, extended flag, then extended bits 17-0
          next_buf_ident[n] = {rx_frame_in.extended ? rx_frame_in.ident[17:0] : 18'h00000,
                               rx_frame_in.extended,
                               rx_frame_in.extended ? rx_frame_in.ident[28:18]
                                                    : rx_frame_in.ident[10:0]};
          next_buf_full[n] = 1'b1;
        end
      end
    end
  end

  // data bytes hold no defined value after power-on
  always_ff @(posedge clk_in)
  begin
    buf_data <= next_buf_data;
    buf_len <= next_buf_len;
    buf_ident <= next_buf_ident;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      buf_full <= 2'h0;
      buf_over <= 2'h0;
    end
    else
    begin
      buf_full <= next_buf_full;
      buf_over <= next_buf_over;
    end
  end

  // filter and mask writes; unimplemented low bits are kept at zero
  always_comb
  begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    next_filt = filt;
    next_mask = mask;
    if (wr_fire)
    begin
      unique case (wr_dec.kind)
        crbfr_pkg::REG_FHIGH:
        begin
          merged = apply_strb({24'h000000, filt[wr_dec.idx].high}, w_data, w_strb);
          next_filt[wr_dec.idx].high = merged[7:0];
        end
        crbfr_pkg::REG_FLOW:
        begin
          merged = apply_strb({24'h000000, filt[wr_dec.idx].low}, w_data, w_strb);
          next_filt[wr_dec.idx].low = merged[7:0] & `CRBFR_FLT_LOW_IMPL;
        end
        crbfr_pkg::REG_FEXT:
        begin
          merged = apply_strb({16'h0000, filt[wr_dec.idx].ext}, w_data, w_strb);
          next_filt[wr_dec.idx].ext = merged[15:0];
        end
        crbfr_pkg::REG_MHIGH:
        begin
          merged = apply_strb({24'h000000, mask[wr_dec.idx].high}, w_data, w_strb);
          next_mask[wr_dec.idx].high = merged[7:0];
        end
        crbfr_pkg::REG_MLOW:
        begin
          merged = apply_strb({24'h000000, mask[wr_dec.idx].low}, w_data, w_strb);
          next_mask[wr_dec.idx].low = merged[7:0] & `CRBFR_MSK_LOW_IMPL;
        end
        crbfr_pkg::REG_MEXT:
        begin
          merged = apply_strb({16'h0000, mask[wr_dec.idx].ext}, w_data, w_strb);
          next_mask[wr_dec.idx].ext = merged[15:0];
        end
        default:
        begin
          merged = 32'h0000_0000;
        end
      endcase
    end
  end

  // zeroed so that an unset filter only passes standard frames
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      filt <= {2{`CRBFR_FLT_RESET}};
      mask <= {2{`CRBFR_FLT_RESET}};
    end
    else
    begin
      filt <= next_filt;
      mask <= next_mask;
    end
  end

  // receive error counting; software writes never reach the counter
  always_comb
  begin
    next_rec = rec;
    if (rx_error_dominant_in)
      next_rec = sat_add(rec, `CRBFR_REC_DOMINANT_STEP);
    else if (rx_error_in)
      next_rec = sat_add(rec, `CRBFR_REC_STEP);
    else if (rx_frame_valid_in)
    begin
      // a good frame pulls a passive count back below the limit
      if (rec > `CRBFR_REC_PASSIVE_LIMIT)
        next_rec = `CRBFR_REC_RELOAD;
      else if (rec != 8'h00)
        next_rec = rec - `CRBFR_REC_STEP;
    end
    // no bus-off output: only the transmit count may do that
    next_passive = (next_rec > `CRBFR_REC_PASSIVE_LIMIT);
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rec <= `CRBFR_REC_RESET;
      passive <= 1'b0;
    end
    else
    begin
      rec <= next_rec;
      passive <= next_passive;
    end
  end

endmodule : crbfr_top
`default_nettype wire

/* File: common/crbfr_map.svh */
`ifndef CRBFR_MAP_SVH
`define CRBFR_MAP_SVH

// buffer bank: two buffers, 0x40 apart, byte m of the data field at +4*m
`define CRBFR_FLT_BASE 12'h080
`define CRBFR_MSK_BASE 12'h0c0
`define CRBFR_BANK_SPAN 12'h020
`define CRBFR_BUF_LEN 6'h20
`define CRBFR_BUF_IDENT 6'h24
`define CRBFR_BUF_STAT 6'h28

// word offsets inside one filter or mask slot
`define CRBFR_ID_HIGH 4'h0
`define CRBFR_ID_LOW 4'h4
`define CRBFR_ID_EXT 4'h8

// stand-alone registers
`define CRBFR_REC 12'h100
`define CRBFR_ERR_STAT 12'h104

// field layouts
`define CRBFR_FLT_LOW_IMPL 8'heb
`define CRBFR_MSK_LOW_IMPL 8'he3
`define CRBFR_LOW_EXT_BIT 3
`define CRBFR_LEN_IMPL 8'h4f
`define CRBFR_LEN_RTR_BIT 6
`define CRBFR_STAT_FULL_BIT 0
`define CRBFR_STAT_INVALID_BIT 1
`define CRBFR_STAT_OVER_BIT 2

// reset values and counter figures
`define CRBFR_REC_RESET 8'h00
`define CRBFR_FLT_RESET 32'h0000_0000
`define CRBFR_REC_PASSIVE_LIMIT 8'h7f
`define CRBFR_REC_RELOAD 8'h77
`define CRBFR_REC_STEP 8'h01
`define CRBFR_REC_DOMINANT_STEP 8'h08
`define CRBFR_LEN_MAX 4'h8

// bus answers
`define CRBFR_RESP_OKAY 2'h0
`define CRBFR_RESP_SLVERR 2'h2

`endif

/* File: common/crbfr_pkg.sv */
package crbfr_pkg;

  // one frame as delivered by the bit-level receiver
  typedef struct packed {
    logic [28:0] ident;
    logic extended;
    logic rtr;
    logic [3:0] length_code;
    logic [7:0][7:0] data;
  } crbfr_frame_t;

  // filter or mask: high byte, low byte, extended 16 bits
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic [15:0] ext;
  } crbfr_ident_t;

  // decoded length code
  typedef struct packed {
    logic [3:0] count;
    logic invalid;
  } crbfr_len_t;

  typedef enum logic [3:0] {
    REG_NONE = 4'h0,
    REG_DATA = 4'h1,
    REG_LEN = 4'h2,
    REG_IDENT = 4'h3,
    REG_STAT = 4'h4,
    REG_FHIGH = 4'h5,
    REG_FLOW = 4'h6,
    REG_FEXT = 4'h7,
    REG_MHIGH = 4'h8,
    REG_MLOW = 4'h9,
    REG_MEXT = 4'ha,
    REG_REC = 4'hb,
    REG_ERR = 4'hc
  } crbfr_kind_t;

  typedef struct packed {
    crbfr_kind_t kind;
    logic idx;
    logic [2:0] byte_sel;
  } crbfr_dec_t;

endpackage : crbfr_pkg

/* File: rtl/crbfr_accept.sv */
`timescale 1ns/1ps
`default_nettype none
`include "crbfr_map.svh"

module crbfr_accept (
  // filter and its mask
  input wire crbfr_pkg::crbfr_ident_t filter_in,
  input wire crbfr_pkg::crbfr_ident_t mask_in,
  // received identifier
  input wire logic [28:0] ident_in,
  input wire logic extended_in,
  // verdict
  output logic hit_out
);

  logic [10:0] sid_filter;
  logic [10:0] sid_mask;
  logic [10:0] sid_frame;
  logic [17:0] eid_filter;
  logic [17:0] eid_mask;
  logic type_ok;
  logic sid_ok;
  logic eid_ok;

  // identifier fields laid out as in the registers
  assign sid_filter = {filter_in.high, filter_in.low[7:5]};
  assign eid_filter = {filter_in.low[1:0], filter_in.ext};
  assign sid_mask = {mask_in.high, mask_in.low[7:5]};
  assign eid_mask = {mask_in.low[1:0], mask_in.ext};
  // extended frames carry the top eleven bits in the standard field
  assign sid_frame = extended_in ? ident_in[28:18] : ident_in[10:0];

  // masked compare, frame type must match the filter's select bit
  assign type_ok = (extended_in == filter_in.low[`CRBFR_LOW_EXT_BIT]);
  assign sid_ok = ((sid_frame ^ sid_filter) & sid_mask) == 11'h000;
  assign eid_ok = !extended_in || (((ident_in[17:0] ^ eid_filter) & eid_mask) == 18'h00000);
  assign hit_out = type_ok && sid_ok && eid_ok;

endmodule : crbfr_accept
`default_nettype wire

/* File: sim/crbfr_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module crbfr_rx_model (
  // clock
  input wire logic clk_in,
  // frames and error events toward the block
  output var crbfr_pkg::crbfr_frame_t frame_out,
  output var logic valid_out,
  output var logic err_out,
  output var logic dom_out
);
  // idle: no pulses at time zero
  initial
  begin
    frame_out = '0;
    valid_out = 1'b0;
    err_out = 1'b0;
    dom_out = 1'b0;
  end

  // one frame, one-cycle valid pulse
  task send(input logic [28:0] id, input logic ext, input logic [3:0] code,
            input logic [63:0] d);
    @(posedge clk_in);
    frame_out <= {id, ext, 1'b0, code, d};
    valid_out <= 1'b1;
    @(posedge clk_in);
    valid_out <= 1'b0;
    frame_out <= ~{id, ext, 1'b0, code, d}; // released lines must not look stale
  endtask : send

  // one receive error, plain or dominant
  task err(input logic dom);
    @(posedge clk_in);
    err_out <= ~dom;
    dom_out <= dom;
    @(posedge clk_in);
    err_out <= 1'b0;
    dom_out <= 1'b0;
  endtask : err
endmodule : crbfr_rx_model
`default_nettype wire

/* File: sim/crbfr_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module crbfr_assertions (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register bus
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  // receive side and status
  input wire logic rx_frame_valid_in,
  input wire logic rx_error_in,
  input wire logic rx_error_dominant_in,
  input wire logic error_passive_out,
  input wire logic [1:0] buffer_full_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // bus answers stand until taken
  a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
  a_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_write_blocked: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken during answer");
  a_read_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken during answer");
  a_error_data_zero: assert property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2 |->
    s_axi_rdata_out == 32'h0) else $error("refused read carries data");
  // passive only entered by errors, left only by a good frame
  a_passive_cause: assert property ($rose(error_passive_out) |->
    $past(rx_error_in || rx_error_dominant_in)) else $error("passive without error");
  a_passive_exit: assert property ($fell(error_passive_out) |-> $past(rx_frame_valid_in))
    else $error("passive left without frame");
  a_full_needs_frame: assert property ($rose(buffer_full_out[0]) || $rose(buffer_full_out[1])
    |-> $past(rx_frame_valid_in)) else $error("buffer filled without frame");

  c_passive: cover property (error_passive_out);
  c_refused: cover property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2);
  c_second_buffer: cover property ($rose(buffer_full_out[1]));
endmodule : crbfr_assertions

bind crbfr_top crbfr_assertions u_chk (.clk_in, .rst_in, .s_axi_awready_out, .s_axi_wready_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out, .rx_frame_valid_in,
  .rx_error_in, .rx_error_dominant_in, .error_passive_out, .buffer_full_out);
`default_nettype wire

/* File: sim/crbfr_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module crbfr_top_bench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic awv = 1'b0, awr, wv = 1'b0, wr_, bv, br = 1'b0, arv = 1'b0, arr, rv, rr = 1'b0, pas;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, rdat, v;
  logic [1:0] bresp, rresp, full, r;
  wire crbfr_pkg::crbfr_frame_t frm;
  wire logic fv, ev, dv;
  int n_mismatch = 0;
  int tests_run = 0;

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  crbfr_rx_model u_rx (.clk_in(clk_in), .frame_out(frm), .valid_out(fv), .err_out(ev),
    .dom_out(dv));
  crbfr_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr_), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rresp), .rx_frame_in(frm), .rx_frame_valid_in(fv), .rx_error_in(ev),
    .rx_error_dominant_in(dv), .error_passive_out(pas), .buffer_full_out(full));

  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  // handshakes judged at negedge where readies are settled, released at next posedge
  task wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic at, wt, bt;
    @(posedge clk_in);
    {awa, wd, awv, wv, br} <= {a, d, 3'b111};
    bt = 1'b0;
    for (n = 0; n < 50 && !bt; n++)
    begin
      @(negedge clk_in);
      {at, wt, bt, r} = {awv && awr, wv && wr_, bv, bresp};
      @(posedge clk_in);
      if (at) awv <= 1'b0;
      if (wt) wv <= 1'b0;
      if (bt) br <= 1'b0;
    end
    chk({31'h0, bt}, 32'h1);
  endtask : wr

  task rd(input logic [11:0] a);
    int n;
    logic at, dt;
    @(posedge clk_in);
    {ara, arv, rr} <= {a, 2'b11};
    dt = 1'b0;
    for (n = 0; n < 50 && !dt; n++)
    begin
      @(negedge clk_in);
      {at, dt, v, r} = {arv && arr, rv, rdat, rresp};
      @(posedge clk_in);
      if (at) arv <= 1'b0;
      if (dt) rr <= 1'b0;
    end
    chk({31'h0, dt}, 32'h1);
  endtask : rd

  task rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask : rchk

  // reset values, access kinds, unmapped place
  task t_regs;
    rchk(12'h100, 32'h0);
    wr(12'h100, 32'hff);
    chk({30'h0, r}, 32'h0);
    rchk(12'h100, 32'h0);
    wr(12'h3fc, 32'h1);
    chk({30'h0, r}, 32'h2);
    wr(12'h080, 32'h1a5);
    rchk(12'h080, 32'ha5);
    wr(12'h084, 32'hff);
    rchk(12'h084, 32'heb);
    wr(12'h0c4, 32'hff);
    rchk(12'h0c4, 32'he3);
    wr(12'h004, 32'h5a);
    rchk(12'h004, 32'h5a);
    rchk(12'h3fc, 32'h0);
    chk({30'h0, r}, 32'h2);
  endtask : t_regs

  // every length code into buffer 0
  task t_len;
    wr(12'h080, 32'h0);
    wr(12'h084, 32'h0);
    wr(12'h0c4, 32'h0);
    wr(12'h094, 32'h8);
    for (int c = 0; c < 16; c++)
    begin
      u_rx.send(29'h123, 1'b0, c[3:0], 64'h8877665544332211);
      rchk(12'h028, c > 8 ? 32'h3 : 32'(c * 16 + 1));
      rchk(12'h020, 32'(c));
      for (int m = 0; m < 8 && c == 8; m++)
        rchk(12'(m * 4), 32'(m * 17 + 17));
      wr(12'h028, 32'h1);
    end
  endtask : t_len

  // mask compare, type select, extended identifier placement
  task t_accept;
    wr(12'h0c0, 32'hff);
    wr(12'h080, 32'h24);
    u_rx.send(29'h3ff, 1'b0, 4'h1, 64'h0);
    @(negedge clk_in);
    chk({30'h0, full}, 32'h0);
    u_rx.send(29'h121, 1'b0, 4'h1, 64'h0);
    u_rx.send(29'h1abcdef1, 1'b1, 4'h1, 64'h0);
    @(negedge clk_in);
    chk({30'h0, full}, 32'h3);
    rchk(12'h064, {2'h0, 18'h0def1, 1'b1, 11'h6af});
    // a second hit on a full buffer keeps it and flags overrun
    u_rx.send(29'h121, 1'b0, 4'h1, 64'h0);
    rchk(12'h028, 32'h15);
    wr(12'h028, 32'h5);
    rchk(12'h028, 32'h10);
    wr(12'h068, 32'h1);
  endtask : t_accept

  // counter up, passive threshold, reload, saturation
  task t_errors;
    repeat (127) u_rx.err(1'b0);
    @(negedge clk_in);
    chk({31'h0, pas}, 32'h0);
    u_rx.err(1'b0);
    rchk(12'h104, 32'h1);
    u_rx.err(1'b1);
    rchk(12'h100, 32'h88);
    u_rx.send(29'h0, 1'b0, 4'h0, 64'h0);
    rchk(12'h100, 32'h77);
    repeat (18) u_rx.err(1'b1);
    rchk(12'h100, 32'hff);
    chk({31'h0, pas}, 32'h1);
  endtask : t_errors

  task summarize;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // main sequence after 20 cycles of reset
  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_len;
    t_accept;
    t_errors;
    summarize;
  end

  // watchdog well past the expected several hundred cycles
  initial
  begin
    #300000;
    n_mismatch++;
    summarize;
  end
endmodule : crbfr_top_bench
`default_nettype wire
